// ### cmd_pkg.sv
// Purpose: constants for the message dma channels of the can controller
// Assumes: one clock, synchronous active-high reset
// Notes: offsets are byte addresses on the plain register port
// Contract
// - tx consumed pointer advances to one past each message sent successfully.
// - a send already underway still advances consumed pointer after disable.
// - tx consumed reaching tx produced after a send raises tx buffer drained event.
// - pointers and thresholds are message indices from base, range set by size.
// - tx consumed reaching tx threshold after a send sets threshold event.
// - rx control has enable at bit 0, read-only in-progress at bit 1.
// - bus error with abort set clears rx channel enable.
// - clearing rx enable never aborts a reception already underway.
// - buffer base held in bits 31..10, low ten bits read zero.
// - size bits 20..6 give size*4 slots, one slot always unused.
// - rx produced pointer advances to one past each message stored.
// - rx produced reaching rx threshold after a store sets threshold event.
// - id accepted when ((id xor code) and mask) is zero; mask resets ones.
// - events set pending bits; interrupt only from pending bits with mask set.
// - reading pending or masked pending view clears all pending bits.
// - writing pending register ors data in, forcing but never clearing.
// - ones written to pending clear register clear matching pending bits.
// - raw and masked status views read without clearing anything.
// - event bit positions 16 down to 0 as in the interrupt layout.
// - bus error with abort disables active channel, blocks bus until status read.
package cmd_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CONF = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_TX_CTRL = 8'h20;
    localparam logic [7:0] OFS_TX_BASE = 8'h24;
    localparam logic [7:0] OFS_TX_SIZE = 8'h28;
    localparam logic [7:0] OFS_TX_WR = 8'h2c;
    localparam logic [7:0] OFS_TX_RD = 8'h30;
    localparam logic [7:0] OFS_TX_THR = 8'h34;
    localparam logic [7:0] OFS_RX_CTRL = 8'h40;
    localparam logic [7:0] OFS_RX_BASE = 8'h44;
    localparam logic [7:0] OFS_RX_SIZE = 8'h48;
    localparam logic [7:0] OFS_RX_WR = 8'h4c;
    localparam logic [7:0] OFS_RX_RD = 8'h50;
    localparam logic [7:0] OFS_RX_THR = 8'h54;
    localparam logic [7:0] OFS_ACC_MASK = 8'h58;
    localparam logic [7:0] OFS_ACC_CODE = 8'h5c;
    localparam logic [7:0] OFS_IRQ_MSTAT = 8'h60;
    localparam logic [7:0] OFS_IRQ_MPEND = 8'h64;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h68;
    localparam logic [7:0] OFS_IRQ_PEND = 8'h6c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h70;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h74;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int PTR_LSB = 4;
    localparam int BASE_LSB = 10;
    localparam int SIZE_LSB = 6;
    localparam int MSG_SHIFT = 4;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 4;
    localparam int STAT_BLOCK_BIT = 3;
    localparam int STAT_OVR_BIT = 2;
    localparam logic [28:0] ACC_MASK_RST = 29'h1fffffff;
    localparam logic [28:0] ACC_CODE_RST = 29'h00000000;
    localparam logic [16:0] IRQ_MASK_RST = 17'h00000;
    // ----------------------------------------
    // event bit positions
    // ----------------------------------------
    localparam int EV_ARB_LOST = 16;
    localparam int EV_FILTERED = 15;
    localparam int EV_TX_ERRINC = 14;
    localparam int EV_RX_ERRINC = 13;
    localparam int EV_SYNC_TX = 12;
    localparam int EV_SYNC_RX = 11;
    localparam int EV_TX_DONE = 10;
    localparam int EV_RX_DONE = 9;
    localparam int EV_TX_DRAINED = 8;
    localparam int EV_RX_FILLED = 7;
    localparam int EV_TX_THR = 6;
    localparam int EV_RX_THR = 5;
    localparam int EV_TX_BUSERR = 4;
    localparam int EV_RX_BUSERR = 3;
    localparam int EV_OVERRUN = 2;
    localparam int EV_BUS_OFF = 1;
    localparam int EV_PASSIVE = 0;
endpackage : cmd_pkg

// ### cmd_dma.sv
// Purpose: transmit and receive message dma channels, acceptance filter, event registers
// Assumes: bus engine moves the four words of a message per mem_req and answers done or err
// Notes: rx has priority on the memory port; a fetched tx message is held for the core
module cmd_dma #(
    parameter int PTR_W = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    input wire logic mem_done,
    input wire logic mem_err,
    output logic tx_msg_valid,
    input wire logic tx_sent,
    input wire logic tx_lost,
    input wire logic rx_id_valid,
    input wire logic [28:0] rx_id,
    input wire logic sync_sent_event,
    input wire logic sync_received_event,
    input wire logic tx_err_inc,
    input wire logic rx_err_inc,
    input wire logic bus_off_event,
    input wire logic passive_event,
    output logic irq
);
    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (PTR_W != 16) begin : g_bad_ptr
        $error("cmd_dma: pointer field is 16 bits wide");
    end

    typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} cmd_tx_st_t;
    typedef enum logic {RX_IDLE, RX_STORE} cmd_rx_st_t;

    cmd_tx_st_t tx_st_q;
    cmd_rx_st_t rx_st_q;
    logic conf_abort_q;
    logic blocked_q;
    logic overrun_q;
    logic tx_en_q;
    logic rx_en_q;
    logic [21:0] tx_base_q;
    logic [21:0] rx_base_q;
    logic [14:0] tx_size_q;
    logic [14:0] rx_size_q;
    logic [15:0] tx_wr_q;
    logic [15:0] tx_rd_q;
    logic [15:0] tx_thr_q;
    logic [15:0] rx_wr_q;
    logic [15:0] rx_rd_q;
    logic [15:0] rx_thr_q;
    logic [28:0] acc_mask_q;
    logic [28:0] acc_code_q;
    logic [16:0] pend_q;
    logic [16:0] imask_q;
    logic [31:0] rdata_q;

    // ----------------------------------------
    // pointer arithmetic
    // ----------------------------------------
    function automatic logic [15:0] nxt(input logic [15:0] p, input logic [14:0] sz);
        logic [16:0] last;
        last = {sz, 2'b00} - 17'h00001;
        return (p == last[15:0]) ? 16'h0000 : p + 16'h0001;
    endfunction : nxt

    wire [15:0] tx_rd_nx = nxt(tx_rd_q, tx_size_q);
    wire [15:0] rx_wr_nx = nxt(rx_wr_q, rx_size_q);
    wire [31:0] tx_msg_addr = {tx_base_q, 10'h000} + {12'h000, tx_rd_q, 4'h0};
    wire [31:0] rx_msg_addr = {rx_base_q, 10'h000} + {12'h000, rx_wr_q, 4'h0};

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire wr_conf = reg_wr && reg_addr == cmd_pkg::OFS_CONF;
    wire wr_tx_ctrl = reg_wr && reg_addr == cmd_pkg::OFS_TX_CTRL;
    wire wr_tx_base = reg_wr && reg_addr == cmd_pkg::OFS_TX_BASE;
    wire wr_tx_size = reg_wr && reg_addr == cmd_pkg::OFS_TX_SIZE;
    wire wr_tx_wr = reg_wr && reg_addr == cmd_pkg::OFS_TX_WR;
    wire wr_tx_rd = reg_wr && reg_addr == cmd_pkg::OFS_TX_RD;
    wire wr_tx_thr = reg_wr && reg_addr == cmd_pkg::OFS_TX_THR;
    wire wr_rx_ctrl = reg_wr && reg_addr == cmd_pkg::OFS_RX_CTRL;
    wire wr_rx_base = reg_wr && reg_addr == cmd_pkg::OFS_RX_BASE;
    wire wr_rx_size = reg_wr && reg_addr == cmd_pkg::OFS_RX_SIZE;
    wire wr_rx_wr = reg_wr && reg_addr == cmd_pkg::OFS_RX_WR;
    wire wr_rx_rd = reg_wr && reg_addr == cmd_pkg::OFS_RX_RD;
    wire wr_rx_thr = reg_wr && reg_addr == cmd_pkg::OFS_RX_THR;
    wire wr_acc_mask = reg_wr && reg_addr == cmd_pkg::OFS_ACC_MASK;
    wire wr_acc_code = reg_wr && reg_addr == cmd_pkg::OFS_ACC_CODE;
    wire wr_pend = reg_wr && reg_addr == cmd_pkg::OFS_IRQ_PEND;
    wire wr_imask = reg_wr && reg_addr == cmd_pkg::OFS_IRQ_MASK;
    wire wr_pclr = reg_wr && reg_addr == cmd_pkg::OFS_IRQ_CLR;
    wire rd_stat = reg_rd && reg_addr == cmd_pkg::OFS_STAT;
    wire rd_pend_clr = reg_rd && (reg_addr == cmd_pkg::OFS_IRQ_PEND
                                  || reg_addr == cmd_pkg::OFS_IRQ_MPEND);
    wire [15:0] wptr = reg_wdata[cmd_pkg::PTR_LSB +: 16];

    // ----------------------------------------
    // memory port sharing
    // ----------------------------------------
    // rx wins the port: a received frame cannot wait, a pending send can
    wire rx_mem = rx_st_q == RX_STORE && !blocked_q;
    wire tx_mem = tx_st_q == TX_FETCH && rx_st_q != RX_STORE && !blocked_q;
    assign mem_req = rx_mem || tx_mem;
    assign mem_write = rx_mem;
    assign mem_addr = rx_mem ? rx_msg_addr : tx_msg_addr;
    wire rx_ok = rx_mem && mem_done;
    wire rx_bad = rx_mem && mem_err;
    wire tx_ok = tx_mem && mem_done;
    wire tx_bad = tx_mem && mem_err;
    wire abort_err = (rx_bad || tx_bad) && conf_abort_q;
    assign tx_msg_valid = tx_st_q == TX_SEND;

    // ----------------------------------------
    // channel conditions
    // ----------------------------------------
    wire tx_pending = tx_en_q && tx_rd_q != tx_wr_q && !blocked_q;
    wire tx_adv = tx_st_q == TX_SEND && tx_sent;
    wire acc_hit = ((rx_id ^ acc_code_q) & acc_mask_q) == 29'h00000000;
    wire rx_full = rx_wr_nx == rx_rd_q;
    wire rx_take = rx_id_valid && rx_en_q && acc_hit;
    wire rx_start = rx_take && rx_st_q == RX_IDLE && !rx_full;
    wire rx_ovr = rx_take && !rx_start;
    wire rx_miss = rx_id_valid && rx_en_q && !acc_hit;

    // ----------------------------------------
    // events
    // ----------------------------------------
    logic [16:0] ev;
    always_comb begin
        ev = 17'h00000;
        ev[cmd_pkg::EV_ARB_LOST] = tx_st_q == TX_SEND && tx_lost;
        ev[cmd_pkg::EV_FILTERED] = rx_miss;
        ev[cmd_pkg::EV_TX_ERRINC] = tx_err_inc;
        ev[cmd_pkg::EV_RX_ERRINC] = rx_err_inc;
        ev[cmd_pkg::EV_SYNC_TX] = sync_sent_event;
        ev[cmd_pkg::EV_SYNC_RX] = sync_received_event;
        ev[cmd_pkg::EV_TX_DONE] = tx_adv;
        ev[cmd_pkg::EV_RX_DONE] = rx_ok;
        ev[cmd_pkg::EV_TX_DRAINED] = tx_adv && tx_rd_nx == tx_wr_q;
        ev[cmd_pkg::EV_RX_FILLED] = rx_ok && nxt(rx_wr_nx, rx_size_q) == rx_rd_q;
        ev[cmd_pkg::EV_TX_THR] = tx_adv && tx_rd_nx == tx_thr_q;
        ev[cmd_pkg::EV_RX_THR] = rx_ok && rx_wr_nx == rx_thr_q;
        ev[cmd_pkg::EV_TX_BUSERR] = tx_bad;
        ev[cmd_pkg::EV_RX_BUSERR] = rx_bad;
        ev[cmd_pkg::EV_OVERRUN] = rx_ovr;
        ev[cmd_pkg::EV_BUS_OFF] = bus_off_event;
        ev[cmd_pkg::EV_PASSIVE] = passive_event;
    end

    // set wins over every clear
    wire [16:0] pend_clr = (rd_pend_clr ? 17'h1ffff : 17'h00000)
                         | (wr_pclr ? reg_wdata[16:0] : 17'h00000);
    wire [16:0] pend_set = ev | (wr_pend ? reg_wdata[16:0] : 17'h00000);
    wire [16:0] pend_d = (pend_q & ~pend_clr) | pend_set;
    assign irq = |(pend_q & imask_q);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h00000000;
        unique case (reg_addr)
            cmd_pkg::OFS_CONF: rmux[0] = conf_abort_q;
            cmd_pkg::OFS_STAT: begin
                rmux[cmd_pkg::STAT_ACTIVE_BIT] = tx_st_q == TX_SEND;
                rmux[cmd_pkg::STAT_BLOCK_BIT] = blocked_q;
                rmux[cmd_pkg::STAT_OVR_BIT] = overrun_q;
            end
            cmd_pkg::OFS_TX_CTRL: begin
                rmux[cmd_pkg::CTRL_EN_BIT] = tx_en_q;
                rmux[cmd_pkg::CTRL_BUSY_BIT] = tx_st_q != TX_IDLE;
            end
            cmd_pkg::OFS_TX_BASE: rmux[31:cmd_pkg::BASE_LSB] = tx_base_q;
            cmd_pkg::OFS_TX_SIZE: rmux[cmd_pkg::SIZE_LSB +: 15] = tx_size_q;
            cmd_pkg::OFS_TX_WR: rmux[cmd_pkg::PTR_LSB +: 16] = tx_wr_q;
            cmd_pkg::OFS_TX_RD: rmux[cmd_pkg::PTR_LSB +: 16] = tx_rd_q;
            cmd_pkg::OFS_TX_THR: rmux[cmd_pkg::PTR_LSB +: 16] = tx_thr_q;
            cmd_pkg::OFS_RX_CTRL: begin
                rmux[cmd_pkg::CTRL_EN_BIT] = rx_en_q;
                rmux[cmd_pkg::CTRL_BUSY_BIT] = rx_st_q == RX_STORE;
            end
            cmd_pkg::OFS_RX_BASE: rmux[31:cmd_pkg::BASE_LSB] = rx_base_q;
            cmd_pkg::OFS_RX_SIZE: rmux[cmd_pkg::SIZE_LSB +: 15] = rx_size_q;
            cmd_pkg::OFS_RX_WR: rmux[cmd_pkg::PTR_LSB +: 16] = rx_wr_q;
            cmd_pkg::OFS_RX_RD: rmux[cmd_pkg::PTR_LSB +: 16] = rx_rd_q;
            cmd_pkg::OFS_RX_THR: rmux[cmd_pkg::PTR_LSB +: 16] = rx_thr_q;
            cmd_pkg::OFS_ACC_MASK: rmux[28:0] = acc_mask_q;
            cmd_pkg::OFS_ACC_CODE: rmux[28:0] = acc_code_q;
            cmd_pkg::OFS_IRQ_MSTAT, cmd_pkg::OFS_IRQ_MPEND: rmux[16:0] = pend_q & imask_q;
            cmd_pkg::OFS_IRQ_STAT, cmd_pkg::OFS_IRQ_PEND: rmux[16:0] = pend_q;
            cmd_pkg::OFS_IRQ_MASK: rmux[16:0] = imask_q;
            default: rmux = 32'h00000000;
        endcase
    end
    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // bus slave and configuration
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= 32'h00000000;
            conf_abort_q <= 1'b0;
            imask_q <= cmd_pkg::IRQ_MASK_RST;
            pend_q <= 17'h00000;
            acc_mask_q <= cmd_pkg::ACC_MASK_RST;
            acc_code_q <= cmd_pkg::ACC_CODE_RST;
        end else begin
            rdata_q <= reg_rd ? rmux : 32'h00000000;
            pend_q <= pend_d;
            if (wr_conf) conf_abort_q <= reg_wdata[0];
            if (wr_imask) imask_q <= reg_wdata[16:0];
            if (wr_acc_mask) acc_mask_q <= reg_wdata[28:0];
            if (wr_acc_code) acc_code_q <= reg_wdata[28:0];
        end
    end

    // status sticky bits: new cause wins over the clearing read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blocked_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            blocked_q <= abort_err || (blocked_q && !rd_stat);
            overrun_q <= rx_ovr || (overrun_q && !rd_stat);
        end
    end

    // ----------------------------------------
    // transmit channel
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_st_q <= TX_IDLE;
            tx_en_q <= 1'b0;
            tx_base_q <= 22'h000000;
            tx_size_q <= 15'h0000;
            tx_wr_q <= 16'h0000;
            tx_rd_q <= 16'h0000;
            tx_thr_q <= 16'h0000;
        end else begin
            if (wr_tx_ctrl) tx_en_q <= reg_wdata[cmd_pkg::CTRL_EN_BIT];
            if (tx_bad && conf_abort_q) tx_en_q <= 1'b0;
            if (wr_tx_base) tx_base_q <= reg_wdata[31:cmd_pkg::BASE_LSB];
            if (wr_tx_size) tx_size_q <= reg_wdata[cmd_pkg::SIZE_LSB +: 15];
            if (wr_tx_wr) tx_wr_q <= wptr;
            if (wr_tx_thr) tx_thr_q <= wptr;
            if (tx_adv) tx_rd_q <= tx_rd_nx;
            else if (wr_tx_rd) tx_rd_q <= wptr;
            unique case (tx_st_q)
                TX_IDLE: if (tx_pending) tx_st_q <= TX_FETCH;
                TX_FETCH: begin
                    if (tx_ok) tx_st_q <= TX_SEND;
                    else if (tx_bad) tx_st_q <= TX_IDLE;
                end
                // a held message keeps going after disable until sent or lost
                TX_SEND: if (tx_sent || tx_lost) tx_st_q <= TX_IDLE;
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // receive channel
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_st_q <= RX_IDLE;
            rx_en_q <= 1'b0;
            rx_base_q <= 22'h000000;
            rx_size_q <= 15'h0000;
            rx_wr_q <= 16'h0000;
            rx_rd_q <= 16'h0000;
            rx_thr_q <= 16'h0000;
        end else begin
            if (wr_rx_ctrl) rx_en_q <= reg_wdata[cmd_pkg::CTRL_EN_BIT];
            if (abort_err) rx_en_q <= 1'b0;
            if (wr_rx_base) rx_base_q <= reg_wdata[31:cmd_pkg::BASE_LSB];
            if (wr_rx_size) rx_size_q <= reg_wdata[cmd_pkg::SIZE_LSB +: 15];
            if (wr_rx_rd) rx_rd_q <= wptr;
            if (wr_rx_thr) rx_thr_q <= wptr;
            if (rx_ok) rx_wr_q <= rx_wr_nx;
            else if (wr_rx_wr) rx_wr_q <= wptr;
            // store ignores the enable once started, so disabling never aborts it
            unique case (rx_st_q)
                RX_IDLE: if (rx_start) rx_st_q <= RX_STORE;
                RX_STORE: if (rx_ok || rx_bad) rx_st_q <= RX_IDLE;
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end
endmodule : cmd_dma

// ### cmd_dma_props.sv
// Purpose: port level checks for the message dma channels
// Assumes: one clock, srst synchronous active high
// Notes: pending events land one edge after their input pulse
module cmd_dma_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic mem_done,
    input wire logic mem_err,
    input wire logic tx_msg_valid,
    input wire logic tx_sent,
    input wire logic tx_lost,
    input wire logic rx_id_valid,
    input wire logic sync_sent_event,
    input wire logic sync_received_event,
    input wire logic tx_err_inc,
    input wire logic rx_err_inc,
    input wire logic bus_off_event,
    input wire logic passive_event,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // ----------------------------------------
    // causes and sequences
    // ----------------------------------------
    // inputs that set pending bits
    wire logic ev_any = reg_wr | mem_done | mem_err | tx_sent | tx_lost | rx_id_valid
        | sync_sent_event | sync_received_event | tx_err_inc | rx_err_inc
        | bus_off_event | passive_event;
    sequence s_wait;
        mem_req && !mem_done && !mem_err;
    endsequence
    sequence s_held;
        tx_msg_valid && !tx_sent && !tx_lost;
    endsequence
    a_addr_align: assert property (mem_req |-> mem_addr[3:0] == 4'h0)
        else $error("message address not on a 16 byte step");
    a_store_hold: assert property (s_wait ##0 mem_write |=> mem_req && mem_write && $stable(mem_addr))
        else $error("store request changed before its answer");
    a_fetch_valid: assert property (mem_req && !mem_write && mem_done |=> tx_msg_valid)
        else $error("fetched message not offered to the core");
    a_fetch_err: assert property (mem_req && !mem_write && mem_err |=> !tx_msg_valid)
        else $error("failed fetch offered to the core");
    a_tx_held: assert property (s_held |=> tx_msg_valid)
        else $error("offered message dropped before the core finished");
    a_tx_release: assert property (tx_msg_valid && (tx_sent || tx_lost) |=> !tx_msg_valid)
        else $error("message still offered after the core finished");
    a_irq_cause: assert property ($rose(irq) |-> $past(ev_any))
        else $error("irq rose with no event behind it");
    a_irq_clear: assert property ($fell(irq) |-> $past(reg_wr || reg_rd || srst))
        else $error("irq fell without a register access");
endmodule : cmd_dma_props

bind cmd_dma cmd_dma_props u_props (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_done(mem_done), .mem_err(mem_err), .tx_msg_valid(tx_msg_valid),
    .tx_sent(tx_sent), .tx_lost(tx_lost), .rx_id_valid(rx_id_valid),
    .sync_sent_event(sync_sent_event), .sync_received_event(sync_received_event),
    .tx_err_inc(tx_err_inc), .rx_err_inc(rx_err_inc), .bus_off_event(bus_off_event),
    .passive_event(passive_event), .irq(irq));

// ### cmd_mem_model.sv
// Purpose: memory bus engine answering whole message transfers
// Assumes: answers wait_cycles+1 edges after the request, with an error while fail_next
// Notes: one answer pulse per request, never while idle
module cmd_mem_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic mem_req,
    input wire logic [1:0] wait_cycles,
    input wire logic fail_next,
    output logic mem_done,
    output logic mem_err
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] cnt_q;
    // ----------------------------------------
    // answer engine
    // ----------------------------------------
    // never a second answer to one request
    always @(posedge sys_clk) begin
        mem_done <= 1'b0;
        mem_err <= 1'b0;
        if (srst) begin
            cnt_q <= 2'h0;
        end else if (mem_req && !mem_done && !mem_err) begin
            if (cnt_q >= wait_cycles) begin
                cnt_q <= 2'h0;
                mem_err <= fail_next;
                mem_done <= !fail_next;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule : cmd_mem_model

// ### testbench.sv
// Purpose: self-checking bench for the message dma channels
// Assumes: 10 MHz clock, memory engine model on the memory port
// Notes: read data and transfer addresses are checked from two queues
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tx_sent = 1'b0;
    logic rx_id_valid = 1'b0;
    logic [28:0] rx_id = 29'h0;
    logic [6:0] ev = 7'h0;
    logic [1:0] wait_cycles = 2'h0;
    logic fail_next = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] reg_rdata, mem_addr, b, c, r, m;
    logic mem_req, mem_write, mem_done, mem_err, tx_msg_valid, irq;
    logic [31:0] exp_rd[$], exp_addr[$];
    int err_total = 0;
    int checks_done = 0;
    int seed = 56226;
    always #50 sys_clk = ~sys_clk;
    cmd_dma uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_done(mem_done), .mem_err(mem_err),
        .tx_msg_valid(tx_msg_valid), .tx_sent(tx_sent), .tx_lost(ev[6]),
        .rx_id_valid(rx_id_valid), .rx_id(rx_id), .sync_sent_event(ev[0]),
        .sync_received_event(ev[1]), .tx_err_inc(ev[2]), .rx_err_inc(ev[3]),
        .bus_off_event(ev[4]), .passive_event(ev[5]), .irq(irq));
    cmd_mem_model u_mem (.sys_clk(sys_clk), .srst(srst), .mem_req(mem_req),
        .wait_cycles(wait_cycles), .fail_next(fail_next), .mem_done(mem_done), .mem_err(mem_err));
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checks_done++;
        if (got !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_rd.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic frame(input logic [28:0] id, input logic [1:0] dly);
        @(posedge sys_clk);
        rx_id <= id;
        rx_id_valid <= 1'b1;
        wait_cycles <= dly;
        @(posedge sys_clk);
        rx_id_valid <= 1'b0;
    endtask : frame
    // bounded wait: message offered or memory port idle
    task automatic wait_on(input bit want_valid);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            #1;
            if (want_valid ? tx_msg_valid === 1'b1 : mem_req === 1'b0) break;
        end
        if (n == 40) begin
            err_total++;
            $display("[FAIL] wait expected done seen timeout");
            stop_test();
        end
    endtask : wait_on
    task automatic send();
        wait_on(1'b1);
        @(posedge sys_clk);
        tx_sent <= 1'b1;
        @(posedge sys_clk);
        tx_sent <= 1'b0;
    endtask : send
    always @(posedge sys_clk) begin
        if (rd_d) chk("reg_rdata", exp_rd.pop_front(), reg_rdata);
        if (mem_req && (mem_done || mem_err)) chk("mem_addr", exp_addr.pop_front(), mem_addr);
        rd_d <= reg_rd && !srst;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(cmd_pkg::OFS_ACC_MASK, 32'h1fffffff);
        rd(cmd_pkg::OFS_IRQ_MASK, 32'h0);
        rd(cmd_pkg::OFS_RX_CTRL, 32'h0);
        wr(cmd_pkg::OFS_RX_BASE, 32'hffffffff);
        rd(cmd_pkg::OFS_RX_BASE, 32'hfffffc00);
        wr(cmd_pkg::OFS_RX_SIZE, 32'hffffffff);
        rd(cmd_pkg::OFS_RX_SIZE, 32'h001fffc0);
        r = ($random(seed) & 32'h1ffff) | 32'h1;
        m = ($random(seed) & 32'h1ffff) | 32'h1;
        wr(cmd_pkg::OFS_IRQ_MASK, m);
        wr(cmd_pkg::OFS_IRQ_PEND, r);
        wr(cmd_pkg::OFS_IRQ_PEND, 32'h0);
        rd(cmd_pkg::OFS_IRQ_STAT, r);
        rd(cmd_pkg::OFS_IRQ_MSTAT, r & m);
        chk("irq", 32'h1, {31'h0, irq});
        c = $random(seed) & 32'h1ffff;
        wr(cmd_pkg::OFS_IRQ_CLR, c);
        rd(cmd_pkg::OFS_IRQ_MPEND, r & ~c & m);
        rd(cmd_pkg::OFS_IRQ_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            ev <= 7'(1 << i);
            @(posedge sys_clk);
            ev <= 7'h0;
        end
        rd(cmd_pkg::OFS_IRQ_PEND, 32'h7803);
        b = $random(seed) & 32'hfffffc00;
        c = $random(seed) & 32'h1fffffff;
        wr(cmd_pkg::OFS_RX_BASE, b);
        wr(cmd_pkg::OFS_RX_SIZE, 32'h40);
        wr(cmd_pkg::OFS_RX_WR, 32'h20);
        wr(cmd_pkg::OFS_RX_RD, 32'h20);
        wr(cmd_pkg::OFS_RX_THR, 32'h30);
        wr(cmd_pkg::OFS_ACC_CODE, c);
        wr(cmd_pkg::OFS_RX_CTRL, 32'h1);
        exp_addr.push_back(b + 32'h20);
        exp_addr.push_back(b + 32'h30);
        exp_addr.push_back(b);
        frame(c[28:0], 2'h3);
        // disabling mid-store must let the store finish
        wr(cmd_pkg::OFS_RX_CTRL, 32'h0);
        rd(cmd_pkg::OFS_RX_CTRL, 32'h2);
        wait_on(1'b0);
        wr(cmd_pkg::OFS_RX_CTRL, 32'h1);
        repeat (3) begin
            frame(c[28:0], 2'($random(seed)));
            wait_on(1'b0);
        end
        frame(c[28:0] ^ 29'h40000, 2'h0);
        wait_on(1'b0);
        rd(cmd_pkg::OFS_RX_WR, 32'h10);
        rd(cmd_pkg::OFS_IRQ_PEND, 32'h82a4);
        r = $random(seed) & 32'hfffffc00;
        wr(cmd_pkg::OFS_TX_BASE, r);
        wr(cmd_pkg::OFS_TX_SIZE, 32'h40);
        wr(cmd_pkg::OFS_TX_RD, 32'h30);
        wr(cmd_pkg::OFS_TX_THR, 32'h0);
        wr(cmd_pkg::OFS_TX_WR, 32'h10);
        exp_addr.push_back(r + 32'h30);
        exp_addr.push_back(r);
        wr(cmd_pkg::OFS_TX_CTRL, 32'h1);
        send();
        wait_on(1'b1);
        ev <= 7'h40;
        @(posedge sys_clk);
        ev <= 7'h0;
        exp_addr.push_back(r);
        wr(cmd_pkg::OFS_TX_CTRL, 32'h0);
        send();
        rd(cmd_pkg::OFS_TX_RD, 32'h10);
        rd(cmd_pkg::OFS_IRQ_PEND, 32'h10540);
        wr(cmd_pkg::OFS_CONF, 32'h1);
        wr(cmd_pkg::OFS_RX_RD, 32'h10);
        fail_next <= 1'b1;
        exp_addr.push_back(b + 32'h10);
        frame(c[28:0], 2'h0);
        wait_on(1'b0);
        fail_next <= 1'b0;
        rd(cmd_pkg::OFS_RX_CTRL, 32'h0);
        rd(cmd_pkg::OFS_IRQ_PEND, 32'h8);
        // blocked until status read
        wr(cmd_pkg::OFS_RX_CTRL, 32'h1);
        frame(c[28:0], 2'h0);
        wait_on(1'b0);
        exp_addr.push_back(b + 32'h10);
        rd(cmd_pkg::OFS_STAT, 32'hc);
        rd(8'h7c, 32'h0);
        repeat (3) @(posedge sys_clk);
        stop_test();
    end
endmodule : testbench
